// [hdl/emps_top.sv]
// Purpose: Multi-pass encoder status, chroma gating, flush and rate registers
// Assumes: Inputs synchronous to ref_clk; status page write is a strobe
// Notes: Register port is a simple read/write strobe pair
`timescale 1ns/1ps
`default_nettype none
module emps_top
   import emps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   // Picture-level state
   input wire logic pic_state_load,
   input wire logic [ERR_FLAGS_W-1:0] pic_err_mask,
   input wire logic pic_second_pass,
   input wire logic pic_streamout_en,
   input wire logic pic_mb_status_rd_en,
   input wire logic pic_conf_report_en,
   input wire logic [4:0] pic_surface_format,
   input wire logic [1:0] pic_codec,
   input wire logic [1:0] pic_mode,
   input wire logic [31:0] pic_target_min_bits,
   input wire logic [31:0] pic_target_max_bits,
   // Macroblock results
   input wire logic mb_valid,
   input wire logic [12:0] mb_bits,
   input wire logic mb_intra,
   input wire logic mb_inter_conf_flag,
   // Slice and frame events
   input wire logic slice_end,
   input wire logic next_cmd_valid,
   input wire logic next_cmd_is_pic_state,
   input wire logic frame_end,
   input wire logic [31:0] frame_bits,
   input wire logic [31:0] frame_stat_word,
   // Explicit flush command
   input wire logic flush_cmd,
   input wire logic flush_media_sel,
   input wire logic flush_cache_req,
   // Context switch request and bitstream decode activity
   input wire logic ctx_switch_req,
   input wire logic bsd_busy,
   // Rate-control status from the encoder core
   input wire logic [31:0] rc_mask_in,
   input wire logic [31:0] rc_status_in,
   input wire logic [31:0] rc_byte_cnt_in,
   input wire logic [31:0] rc_zpad_cnt_in,
   input wire logic [31:0] rc_dq_in,
   input wire logic [31:0] rc_dlf_in,
   // Register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [19:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // Status page write
   output logic status_wr,
   output logic [31:0] status_word,
   output logic stats_wr,
   output logic [31:0] stats_word,
   // Pipe controls
   output logic chroma_rd_en,
   output logic chroma_proc_en,
   output logic chroma_wr_en,
   output logic chroma_filt_en,
   output logic chroma_coef_expect,
   output logic streamout_en,
   output logic mb_status_rd_en,
   output logic pipe_flush,
   output logic media_flush,
   output logic gfx_flush,
   output logic cache_flush,
   output logic ctx_switch_ack
);
   // ------------------------------------------------------------
   // Picture state
   // ------------------------------------------------------------
   logic [ERR_FLAGS_W-1:0] mask_ff;
   logic conf_rep_ff;
   logic so_ff;
   logic mbs_ff;
   logic mono_ff;
   logic [1:0] codec_ff;
   logic [1:0] mode_ff;
   logic [31:0] tmin_ff;
   logic [31:0] tmax_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         mask_ff <= '0;
         conf_rep_ff <= 1'b0;
         so_ff <= 1'b0;
         mbs_ff <= 1'b0;
         mono_ff <= 1'b0;
         codec_ff <= CODEC_AVC;
         mode_ff <= MODE_ENCODE;
         tmin_ff <= REG_RESET_VAL;
         tmax_ff <= REG_RESET_VAL;
      end
      else if (pic_state_load)
      begin
         mask_ff <= pic_err_mask;
         // Second pass forces its own settings whatever the state says
         conf_rep_ff <= pic_conf_report_en && !pic_second_pass;
         so_ff <= pic_streamout_en && !pic_second_pass;
         mbs_ff <= pic_mb_status_rd_en || pic_second_pass;
         mono_ff <= (pic_surface_format == FMT_MONOCHROME);
         codec_ff <= pic_codec;
         mode_ff <= pic_mode;
         tmin_ff <= pic_target_min_bits;
         tmax_ff <= pic_target_max_bits;
      end
   end

   // ------------------------------------------------------------
   // Chroma traffic gating
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         chroma_rd_en <= 1'b0;
         chroma_proc_en <= 1'b0;
         chroma_wr_en <= 1'b0;
         chroma_filt_en <= 1'b0;
         chroma_coef_expect <= 1'b0;
         streamout_en <= 1'b0;
         mb_status_rd_en <= 1'b0;
      end
      else
      begin
         chroma_rd_en <= !mono_ff && (mode_ff == MODE_ENCODE);
         chroma_proc_en <= !mono_ff;
         chroma_wr_en <= !mono_ff;
         chroma_filt_en <= !mono_ff && (mode_ff != MODE_IT);
         chroma_coef_expect <= !mono_ff && (mode_ff == MODE_IT);
         streamout_en <= so_ff;
         mb_status_rd_en <= mbs_ff;
      end
   end

   // ------------------------------------------------------------
   // Per-macroblock flags and error word
   // ------------------------------------------------------------
   logic [ERR_FLAGS_W-1:0] mb_flags;
   logic [ERR_FLAGS_W-1:0] err_word;
   logic err_clear;
   logic range_err;

   always_comb
   begin
      mb_flags = '0;
      mb_flags[ERR_CONF_BIT] = conf_rep_ff && mb_intra && (mb_bits > MB_CONF_LIMIT);
      mb_flags[ERR_INTER_BIT] = mb_inter_conf_flag && !mb_intra;
   end

   // Frame range check folds in as one more flag at frame end
   assign range_err = (frame_bits > tmax_ff) || (frame_bits < tmin_ff);

   emps_err_merge u_merge
   (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(err_clear),
      .mb_valid(mb_valid || frame_end),
      .mb_flags(frame_end ? {{(ERR_FLAGS_W-2){1'b0}}, range_err, 1'b0} : mb_flags),
      .mask(mask_ff),
      .err_word(err_word)
   );

   // ------------------------------------------------------------
   // Pass sequencing
   // ------------------------------------------------------------
   emps_state_e state_ff;
   emps_state_e nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         EMPS_IDLE: if (pic_state_load) nxt_state = EMPS_PASS;
         EMPS_PASS: if (frame_end) nxt_state = EMPS_REPORT;
         EMPS_REPORT: nxt_state = EMPS_DONE;
         EMPS_DONE: nxt_state = EMPS_IDLE;
         default: nxt_state = EMPS_IDLE;
      endcase
   end

   assign err_clear = (state_ff == EMPS_DONE);

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         state_ff <= EMPS_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Error word lands two cycles after frame end, once the range flag is in
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         status_wr <= 1'b0;
         status_word <= REG_RESET_VAL;
      end
      else
      begin
         status_wr <= (state_ff == EMPS_REPORT);
         if (state_ff == EMPS_REPORT)
            status_word <= {{(32-ERR_FLAGS_W){1'b0}}, err_word};
      end
   end

   // Each pass rewrites the same statistics slot, so the last pass wins
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         stats_wr <= 1'b0;
         stats_word <= REG_RESET_VAL;
      end
      else
      begin
         stats_wr <= frame_end;
         if (frame_end)
            stats_word <= frame_stat_word;
      end
   end

   // ------------------------------------------------------------
   // Pipeline flush
   // ------------------------------------------------------------
   logic slice_flush;
   logic mpeg2_flush;

   assign slice_flush = slice_end && (codec_ff == CODEC_AVC || codec_ff == CODEC_VC1);
   assign mpeg2_flush = (codec_ff == CODEC_MPEG2) && next_cmd_valid
      && next_cmd_is_pic_state;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         pipe_flush <= 1'b0;
         media_flush <= 1'b0;
         gfx_flush <= 1'b0;
         cache_flush <= 1'b0;
      end
      else
      begin
         pipe_flush <= slice_flush || mpeg2_flush || flush_cmd;
         media_flush <= flush_cmd && flush_media_sel;
         gfx_flush <= flush_cmd && !flush_media_sel;
         cache_flush <= flush_cmd && flush_cache_req;
      end
   end

   // ------------------------------------------------------------
   // Context switch
   // ------------------------------------------------------------
   logic ctx_pend_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         ctx_pend_ff <= 1'b0;
         ctx_switch_ack <= 1'b0;
      end
      else
      begin
         // Acknowledge only between pictures and never during bitstream decode
         ctx_switch_ack <= 1'b0;
         if (ctx_pend_ff && (state_ff == EMPS_IDLE) && !bsd_busy)
         begin
            ctx_switch_ack <= 1'b1;
            ctx_pend_ff <= 1'b0;
         end
         else if (ctx_switch_req)
            ctx_pend_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Rate-control registers
   // ------------------------------------------------------------
   logic [31:0] cum_dq01_ff;
   logic [31:0] cum_dq23_ff;
   logic [31:0] cum_lf01_ff;
   logic [31:0] cum_lf23_ff;
   logic [31:0] conv_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cum_dq01_ff <= REG_RESET_VAL;
         cum_dq23_ff <= REG_RESET_VAL;
         cum_lf01_ff <= REG_RESET_VAL;
         cum_lf23_ff <= REG_RESET_VAL;
         conv_ff <= REG_RESET_VAL;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            CUM_QINDEX_SEG01_OFS: cum_dq01_ff <= reg_wdata;
            CUM_QINDEX_SEG23_OFS: cum_dq23_ff <= reg_wdata;
            CUM_LF_SEG01_OFS: cum_lf01_ff <= reg_wdata;
            CUM_LF_SEG23_OFS: cum_lf23_ff <= reg_wdata;
            RC_CONVERGE_OFS: conv_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   logic [31:0] nxt_rdata;

   always_comb
   begin
      case (reg_addr)
         RC_PARAM_MASK_OFS: nxt_rdata = rc_mask_in;
         RC_PARAM_STATUS_OFS: nxt_rdata = rc_status_in;
         FRAME_OUT_BYTES_OFS: nxt_rdata = rc_byte_cnt_in;
         FRAME_ZPAD_BYTES_OFS: nxt_rdata = rc_zpad_cnt_in;
         RC_DELTA_QINDEX_OFS: nxt_rdata = rc_dq_in;
         RC_DELTA_LF_OFS: nxt_rdata = rc_dlf_in;
         CUM_QINDEX_SEG01_OFS: nxt_rdata = cum_dq01_ff;
         CUM_QINDEX_SEG23_OFS: nxt_rdata = cum_dq23_ff;
         CUM_LF_SEG01_OFS: nxt_rdata = cum_lf01_ff;
         CUM_LF_SEG23_OFS: nxt_rdata = cum_lf23_ff;
         RC_CONVERGE_OFS: nxt_rdata = conv_ff;
         // Holes read as zero
         default: nxt_rdata = REG_RESET_VAL;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         reg_rdata <= REG_RESET_VAL;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= nxt_rdata;
      end
   end
endmodule // emps_top
`default_nettype wire

// [hdl/emps_pkg.sv]
// Purpose: Shared constants for the encoder multi-pass status block
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes: Register offsets are byte addresses as printed (one is unaligned)
package emps_pkg;
   // ------------------------------------------------------------
   // Register map of the second video box
   // ------------------------------------------------------------
   localparam logic [19:0] RC_PARAM_MASK_OFS = 20'h1C900;
   localparam logic [19:0] RC_PARAM_STATUS_OFS = 20'h1C904;
   localparam logic [19:0] FRAME_OUT_BYTES_OFS = 20'h1C908;
   localparam logic [19:0] FRAME_ZPAD_BYTES_OFS = 20'h1C90B;
   localparam logic [19:0] RC_DELTA_QINDEX_OFS = 20'h1C910;
   localparam logic [19:0] RC_DELTA_LF_OFS = 20'h1C914;
   localparam logic [19:0] CUM_QINDEX_SEG01_OFS = 20'h1C918;
   localparam logic [19:0] CUM_QINDEX_SEG23_OFS = 20'h1C91C;
   localparam logic [19:0] CUM_LF_SEG01_OFS = 20'h1C920;
   localparam logic [19:0] CUM_LF_SEG23_OFS = 20'h1C924;
   localparam logic [19:0] RC_CONVERGE_OFS = 20'h1C928;
   localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
   // ------------------------------------------------------------
   // Error word layout
   // ------------------------------------------------------------
   localparam int ERR_FLAGS_W = 8;
   localparam int ERR_CONF_BIT = 0;
   localparam int ERR_RANGE_BIT = 1;
   localparam int ERR_INTER_BIT = 2;
   localparam int MB_CONF_LIMIT_BITS = 3200;
   localparam logic [12:0] MB_CONF_LIMIT = 13'd3200;
   // ------------------------------------------------------------
   // Surface format and codecs
   // ------------------------------------------------------------
   localparam logic [4:0] FMT_MONOCHROME = 5'd12;
   localparam logic [1:0] CODEC_AVC = 2'h0;
   localparam logic [1:0] CODEC_VC1 = 2'h1;
   localparam logic [1:0] CODEC_MPEG2 = 2'h2;
   localparam logic [1:0] MODE_ENCODE = 2'h0;
   localparam logic [1:0] MODE_VLD = 2'h1;
   localparam logic [1:0] MODE_IT = 2'h2;
   typedef enum logic [3:0]
   {
      EMPS_IDLE = 4'b0001,
      EMPS_PASS = 4'b0010,
      EMPS_REPORT = 4'b0100,
      EMPS_DONE = 4'b1000
   } emps_state_e;
endpackage

// [hdl/emps_err_merge.sv]
// Purpose: Folds per-macroblock conformance flags into the sticky error word
// Assumes: Flags valid when mb_valid is high
// Notes: One generate loop over the eight flag positions
`timescale 1ns/1ps
`default_nettype none
module emps_err_merge
   import emps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic mb_valid,
   input wire logic [ERR_FLAGS_W-1:0] mb_flags,
   input wire logic [ERR_FLAGS_W-1:0] mask,
   output logic [ERR_FLAGS_W-1:0] err_word
);
   genvar gi;
   generate
      for (gi = 0; gi < ERR_FLAGS_W; gi++)
      begin : g_flag
         logic flag_ff;
         always_ff @(posedge ref_clk)
         begin
            if (!nrst)
               flag_ff <= 1'b0;
            else if (mb_valid && mb_flags[gi] && mask[gi])
               flag_ff <= 1'b1;
            else if (clear)
               flag_ff <= 1'b0;
         end
         assign err_word[gi] = flag_ff;
      end
   endgenerate
endmodule // emps_err_merge
`default_nettype wire

// [verification/emps_top_properties.sv]
// Purpose: Port-level checks for the multi-pass status block
// Assumes: One clock, synchronous active-low reset
// Notes: The codec is shadowed here to judge flush timing
`timescale 1ns/1ps
`default_nettype none
module emps_top_properties
   import emps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic pic_state_load,
   input wire logic pic_second_pass,
   input wire logic slice_end,
   input wire logic next_cmd_valid,
   input wire logic next_cmd_is_pic_state,
   input wire logic frame_end,
   input wire logic flush_cmd,
   input wire logic flush_media_sel,
   input wire logic flush_cache_req,
   input wire logic bsd_busy,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic status_wr,
   input wire logic stats_wr,
   input wire logic chroma_rd_en,
   input wire logic chroma_proc_en,
   input wire logic chroma_wr_en,
   input wire logic chroma_filt_en,
   input wire logic chroma_coef_expect,
   input wire logic streamout_en,
   input wire logic mb_status_rd_en,
   input wire logic pipe_flush,
   input wire logic media_flush,
   input wire logic gfx_flush,
   input wire logic cache_flush,
   input wire logic ctx_switch_ack,
   input wire logic [4:0] pic_surface_format,
   input wire logic [1:0] pic_codec,
   input wire logic [31:0] frame_stat_word,
   input wire logic [31:0] status_word,
   input wire logic [31:0] stats_word
);
   logic [1:0] codec_ff;
   logic chroma_any;
   assign chroma_any = chroma_rd_en | chroma_proc_en | chroma_wr_en | chroma_filt_en
      | chroma_coef_expect;
   always_ff @(posedge ref_clk)
      if (!nrst)
         codec_ff <= CODEC_AVC;
      else if (pic_state_load)
         codec_ff <= pic_codec;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence frame_close;
      frame_end ##1 stats_wr;
   endsequence
   AST_STATS_COPY: assert property (frame_end |=>
      stats_wr && stats_word == $past(frame_stat_word))
      else $error("statistics word not copied");
   AST_STATUS_WRITE: assert property (frame_close |=> status_wr)
      else $error("status word not written");
   AST_STATUS_CAUSE: assert property (status_wr |-> $past(frame_end, 2))
      else $error("status write without frame end");
   AST_STATUS_LAYOUT: assert property (status_wr |-> status_word[31:3] == 29'h0)
      else $error("reserved status bits set");
   AST_MONO_GATE: assert property (pic_state_load &&
      pic_surface_format == FMT_MONOCHROME |-> ##2 !chroma_any)
      else $error("chroma traffic in monochrome");
   AST_SECOND_PASS: assert property (pic_state_load && pic_second_pass |->
      ##2 (!streamout_en && mb_status_rd_en))
      else $error("second pass controls wrong");
   AST_SLICE_FLUSH: assert property (slice_end && codec_ff != CODEC_MPEG2 |=> pipe_flush)
      else $error("no flush at slice end");
   AST_LOOKAHEAD_FLUSH: assert property (codec_ff == CODEC_MPEG2 &&
      next_cmd_valid && next_cmd_is_pic_state |=> pipe_flush)
      else $error("no flush before picture state");
   AST_MPEG2_QUIET: assert property (codec_ff == CODEC_MPEG2 &&
      !next_cmd_valid && !flush_cmd |=> !pipe_flush)
      else $error("unexpected flush in slice stream");
   AST_EXPLICIT_FLUSH: assert property (flush_cmd |=>
      media_flush == $past(flush_media_sel) && gfx_flush == !$past(flush_media_sel)
      && cache_flush == $past(flush_cache_req))
      else $error("explicit flush outputs wrong");
   AST_CTX_AFTER_DECODE: assert property (ctx_switch_ack |->
      !$past(bsd_busy) && !$past(ctx_switch_ack))
      else $error("context ack during decode");
   AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   cover property (frame_close ##1 status_wr);
endmodule // emps_top_properties
bind emps_top emps_top_properties emps_top_properties_i (.*);
`default_nettype wire

// [verification/emps_streamer_model.sv]
// Purpose: Command streamer side of the conditional batch end
// Assumes: The status page holds the last word written
// Notes: Compare enable and data word come from the bench
`timescale 1ns/1ps
`default_nettype none
module emps_streamer_model
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic status_wr,
   input wire logic [31:0] status_word,
   input wire logic cmp_en,
   input wire logic [31:0] cmp_data,
   output logic skip_pass
);
   logic [31:0] page_ff;
   always_ff @(posedge ref_clk)
      if (!nrst)
         page_ff <= 32'h0000_0000;
      else if (status_wr)
         page_ff <= status_word;
   // Unsigned compare: any error bit makes the page exceed a zero data word
   assign skip_pass = cmp_en && !(page_ff > cmp_data);
endmodule // emps_streamer_model
`default_nettype wire

// [verification/test_encoder_multipass_status.sv]
// Purpose: Directed bench for the multi-pass status block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every frame reloads the full picture state
`timescale 1ns/1ps
`default_nettype none
module test_encoder_multipass_status
   import emps_pkg::*;
;
   logic ref_clk, nrst, pic_state_load, pic_second_pass, pic_streamout_en, mb_valid;
   logic pic_mb_status_rd_en, pic_conf_report_en, mb_intra, mb_inter_conf_flag, slice_end;
   logic next_cmd_valid, next_cmd_is_pic_state, frame_end, flush_cmd, flush_media_sel;
   logic flush_cache_req, ctx_switch_req, bsd_busy, reg_wr, reg_rd, reg_rvalid, status_wr;
   logic stats_wr, chroma_rd_en, chroma_proc_en, chroma_wr_en, chroma_filt_en, skip_pass;
   logic chroma_coef_expect, streamout_en, mb_status_rd_en, pipe_flush, media_flush;
   logic gfx_flush, cache_flush, ctx_switch_ack, cmp_en;
   logic [7:0] pic_err_mask;
   logic [4:0] pic_surface_format;
   logic [1:0] pic_codec, pic_mode;
   logic [12:0] mb_bits;
   logic [19:0] reg_addr;
   logic [31:0] pic_target_min_bits, pic_target_max_bits, frame_bits, frame_stat_word;
   logic [31:0] rc_mask_in, rc_status_in, rc_byte_cnt_in, rc_zpad_cnt_in, rc_dq_in;
   logic [31:0] rc_dlf_in, reg_wdata, reg_rdata, status_word, stats_word;
   logic [19:0] ofs [11] = '{RC_PARAM_MASK_OFS, RC_PARAM_STATUS_OFS, FRAME_OUT_BYTES_OFS,
      FRAME_ZPAD_BYTES_OFS, RC_DELTA_QINDEX_OFS, RC_DELTA_LF_OFS, CUM_QINDEX_SEG01_OFS,
      CUM_QINDEX_SEG23_OFS, CUM_LF_SEG01_OFS, CUM_LF_SEG23_OFS, RC_CONVERGE_OFS};
   int num_errors, tests_run, n;
   emps_top emps_top_i (.*);
   emps_streamer_model emps_streamer_model_i (.ref_clk(ref_clk), .nrst(nrst),
      .status_wr(status_wr), .status_word(status_word), .cmp_en(cmp_en),
      .cmp_data(32'h0000_0000), .skip_pass(skip_pass));
   always #25 ref_clk = ~ref_clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pulse(ref logic s);
      @(posedge ref_clk);
      #1 s = 1'b1;
      @(posedge ref_clk);
      #1 s = 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] e);
      reg_addr = a;
      pulse(reg_rd);
      chk("rdata", {1'b1, e}, {reg_rvalid, reg_rdata});
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      pulse(reg_wr);
   endtask
   task automatic frame(input logic [7:0] m, input logic sp, input logic [12:0] b,
      input logic [1:0] ty, input logic [31:0] fb, input logic [31:0] e);
      pic_err_mask = m;
      pic_second_pass = sp;
      pulse(pic_state_load);
      {mb_intra, mb_inter_conf_flag} = ty;
      mb_bits = b;
      pulse(mb_valid);
      frame_bits = fb;
      frame_stat_word = fb ^ 32'h5A5A_0000;
      pulse(frame_end);
      chk("stats", {1'b1, fb ^ 32'h5A5A_0000}, {stats_wr, stats_word});
      for (n = 0; n < 6 && status_wr !== 1'b1; n++)
         @(posedge ref_clk) #1;
      chk("status", {1'b1, e}, {status_wr, status_word});
      if (status_wr !== 1'b1)
         close_out();
      @(posedge ref_clk);
      #1 chk("skip", {32'h0, e == 32'h0}, {32'h0, skip_pass});
      chk("so_mbs", {31'h0, !sp, sp}, {31'h0, streamout_en, mb_status_rd_en});
   endtask
   initial
   begin
      {ref_clk, nrst, pic_state_load, pic_second_pass, mb_valid, mb_intra, slice_end} = '0;
      {mb_inter_conf_flag, next_cmd_valid, next_cmd_is_pic_state, frame_end, flush_cmd} = '0;
      {flush_media_sel, flush_cache_req, ctx_switch_req, bsd_busy, reg_wr, reg_rd} = '0;
      {cmp_en, pic_streamout_en, pic_mb_status_rd_en, pic_conf_report_en} = 4'b1101;
      {pic_err_mask, pic_surface_format, pic_codec, pic_mode, mb_bits, reg_addr} = '0;
      {frame_bits, frame_stat_word, reg_wdata, rc_mask_in, rc_status_in} = '0;
      {rc_byte_cnt_in, rc_zpad_cnt_in, rc_dq_in, rc_dlf_in} = '0;
      pic_target_min_bits = 32'd100;
      pic_target_max_bits = 32'd1000;
      repeat (2) @(posedge ref_clk);
      #1 nrst = 1'b1;
      // Read-only places track the live core values, so change them between reads
      for (int k = 0; k < 2; k++)
      begin
         {rc_mask_in, rc_status_in, rc_byte_cnt_in} = {k[3:0], 28'h1, k[3:0], 28'h2,
            k[3:0], 28'h3};
         {rc_zpad_cnt_in, rc_dq_in, rc_dlf_in} = {k[3:0], 28'h4, k[3:0], 28'h5,
            k[3:0], 28'h6};
         for (int i = 0; i < 6; i++)
            rd(ofs[i], {k[3:0], 28'(i + 1)});
      end
      for (int i = 6; i < 11; i++)
      begin
         rd(ofs[i], REG_RESET_VAL);
         wr(ofs[i], {4'hC, 28'(i)});
         rd(ofs[i], {4'hC, 28'(i)});
      end
      wr(ofs[0], 32'hFFFF_FFFF);
      rd(ofs[0], {4'h1, 28'h1});
      rd(20'h1C92C, 32'h0000_0000);
      $display("test registers done");
      // Full picture state is sent ahead of every frame, as a preamble would be
      frame(8'h07, 1'b0, 13'd3201, 2'b10, 32'd500, 32'h1);
      frame(8'h07, 1'b0, 13'd3200, 2'b10, 32'd1000, 32'h0);
      frame(8'h06, 1'b0, 13'd3201, 2'b01, 32'd1001, 32'h6);
      frame(8'h06, 1'b0, 13'd3201, 2'b10, 32'd500, 32'h0);
      frame(8'h02, 1'b0, 13'd10, 2'b01, 32'd99, 32'h2);
      frame(8'h07, 1'b1, 13'd3201, 2'b10, 32'd100, 32'h0);
      // Page now holds zero, so only the compare enable keeps the skip off
      cmp_en = 1'b0;
      @(posedge ref_clk) #1 chk("skip_off", 33'h0, {32'h0, skip_pass});
      cmp_en = 1'b1;
      $display("test multipass done");
      pic_surface_format = FMT_MONOCHROME;
      for (int md = 0; md < 3; md++)
      begin
         pic_mode = md[1:0];
         frame(8'h00, 1'b0, 13'd0, 2'b00, 32'd500, 32'h0);
         chk("chroma", 33'h0, {28'h0, chroma_rd_en, chroma_proc_en, chroma_wr_en,
            chroma_filt_en, chroma_coef_expect});
      end
      {pic_surface_format, pic_mode} = '0;
      $display("test monochrome done");
      for (int c = 0; c < 3; c++)
      begin
         pic_codec = c[1:0];
         frame(8'h00, 1'b0, 13'd0, 2'b00, 32'd500, 32'h0);
         chk("chroma_on", {28'h0, 5'b11110}, {28'h0, chroma_rd_en, chroma_proc_en,
            chroma_wr_en, chroma_filt_en, chroma_coef_expect});
         pulse(slice_end);
         chk("slice_flush", {32'h0, c != 2}, {32'h0, pipe_flush});
      end
      next_cmd_is_pic_state = 1'b1;
      pulse(next_cmd_valid);
      chk("ahead_flush", 33'h1, {32'h0, pipe_flush});
      next_cmd_is_pic_state = 1'b0;
      for (int j = 0; j < 4; j++)
      begin
         {flush_media_sel, flush_cache_req} = j[1:0];
         pulse(flush_cmd);
         chk("flush", {30'h0, j[1], !j[1], j[0]}, {30'h0, media_flush, gfx_flush,
            cache_flush});
      end
      $display("test flush done");
      // A request inside a picture waits for the picture to close
      pulse(pic_state_load);
      pulse(ctx_switch_req);
      for (int w = 0; w < 4; w++)
         #50 chk("ctx_mid_pic", 33'h0, {32'h0, ctx_switch_ack});
      pulse(frame_end);
      for (n = 0; n < 8 && ctx_switch_ack !== 1'b1; n++)
         @(posedge ref_clk) #1;
      chk("ctx_pic_end", 33'h1, {32'h0, ctx_switch_ack});
      bsd_busy = 1'b1;
      pulse(ctx_switch_req);
      for (int w = 0; w < 4; w++)
         #50 chk("ctx_hold", 33'h0, {32'h0, ctx_switch_ack});
      bsd_busy = 1'b0;
      for (n = 0; n < 8 && ctx_switch_ack !== 1'b1; n++)
         @(posedge ref_clk) #1;
      chk("ctx_ack", 33'h1, {32'h0, ctx_switch_ack});
      $display("test context done");
      close_out();
   end
endmodule // test_encoder_multipass_status
`default_nettype wire
